// ---- design/ext_bus_consts.svh ----
// constants for the external system bus and hold port
// assumes inclusion by bare name from package and modules
//
// Overview of operation
// - space_select low for user space, high for I/O space during own cycles.
// - byte_lane_high qualifies D0..D7 upper byte, byte_lane_low D8..D15 lower byte.
// - reads drive both byte lanes low; only needed bytes are kept.
// - writes drive low only the lanes of the bytes written.
// - cycle_begin_strobe pulses low at the start of each external cycle.
// - each transfer inside a burst gets its own begin strobe.
// - internal DRAM or internal I/O accesses give no external begin strobe.
// - fetch_kind low for instruction fetch, high for operand access.
// - device drives read/write in own cycles; external master drives it in hold.
// - aligned 32-bit access runs as two 16-bit cycles, multi flag low.
// - 32-bit access sends upper half first: A30 low, then high.
// - fetch burst up to 8 cycles over a 128-bit block, 8 in cache mode.
// - multi_cycle_flag stays low across all cycles of one access.
// - 128-bit burst starts on any halfword and wraps within the block.
// - own cycles wait until slave asserts transfer_done.
// - in hold, device drives transfer_done when an external DRAM cycle completes.
// - hold_request low asks for the bus; device enters hold.
// - in hold the device asserts hold_grant.
// - in hold address and control pins are released; data and transfer_done are driven only for DRAM access.
// - in hold, chip select low makes device access DRAM at the given address.
// - system break is not masked by irq enable; wakes sleep, starts slave.
// - external interrupt requests irq only while irq enable is set; wakes sleep, starts slave mode.
`ifndef EXT_BUS_CONSTS_SVH
`define EXT_BUS_CONSTS_SVH
`define ADDR_W        23
`define DATA_W        16
`define BURST_MAX     4'h8
`define BURST_IDX_W   3
`define DRAM_ADDR_W   20
`define DRAM_LAT      2'h1
`define DRAM_CHUNK_W  1
`endif

// ---- design/ext_bus_pkg.sv ----
// types for the external system bus and hold port
// assumes ext_bus_consts.svh on the include path
`include "ext_bus_consts.svh"
package ext_bus_pkg;
    typedef enum logic [1:0] {
        req_half  = 2'h0,
        req_word  = 2'h1,
        req_block = 2'h2
    } req_size_t;

    typedef struct packed {
        logic [`ADDR_W-1:0] addr;     // halfword address, msb is bit 8
        logic               io_space;
        logic               fetch;
        logic               write;
        req_size_t          size;
        logic [3:0]         beats;    // block length, 1..8
        logic [1:0]         lanes_n;  // low active write lanes, [1]=high byte
        logic [31:0]        wdata;
    } bus_req_t;

    typedef struct packed {
        logic               space_select;
        logic               byte_lane_high_n;
        logic               byte_lane_low_n;
        logic               cycle_begin_strobe_n;
        logic               fetch_kind;
        logic               rd_wr_n;
        logic               multi_cycle_flag_n;
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] data;
    } bus_pins_t;
endpackage : ext_bus_pkg

// ---- design/dram_store.sv ----
// small halfword memory standing in for the internal DRAM window
// assumes one clock; read data registered
`timescale 1ns/1ps
`include "ext_bus_consts.svh"
module dram_store #(
    parameter int AW = `DRAM_ADDR_W
) (
    // clock
    input  wire logic          ref_clk,
    // access
    input  wire logic          en,
    input  wire logic          we,
    input  wire logic [1:0]    lanes,
    input  wire logic [AW-1:0] addr,
    input  wire logic [15:0]   wdata,
    output logic      [15:0]   rdata
);
    logic [15:0] mem [0:(1<<AW)-1];

    // byte-lane write and registered read
    always_ff @(posedge ref_clk) begin
        if (en) begin
            if (we && lanes[1]) begin
                mem[addr][15:8] <= wdata[15:8];
            end
            if (we && lanes[0]) begin
                mem[addr][7:0] <= wdata[7:0];
            end
            rdata <= mem[addr];
        end
    end
endmodule : dram_store

// ---- design/ext_bus_port.sv ----
// external bus master sequencer with hold port for internal DRAM
// assumes pins are synchronised here; DRAM is a local store
`timescale 1ns/1ps
`include "ext_bus_consts.svh"
module ext_bus_port
    import ext_bus_pkg::*;
#(
    parameter int DRAM_AW = `DRAM_ADDR_W
) (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    // core request side
    input  wire logic                   req_valid,
    output logic                        req_ready,
    input  wire ext_bus_pkg::bus_req_t  req,
    input  wire logic                   req_internal,
    output logic                        rsp_valid,
    output logic [31:0]                 rsp_data,
    // bus pins out
    output ext_bus_pkg::bus_pins_t      pin_o,
    output logic                        pin_oe,
    output logic                        data_oe,
    output logic                        done_o_n,
    output logic                        done_oe,
    // bus pins in
    input  wire ext_bus_pkg::bus_pins_t pin_i,
    input  wire logic                   done_i_n,
    input  wire logic                   hold_request_n,
    input  wire logic                   chip_select_n,
    output logic                        hold_grant_n,
    // interrupt pins and core side
    input  wire logic                   system_break_irq_n,
    input  wire logic                   ext_irq_n,
    input  wire logic                   irq_enable_flag,
    input  wire logic                   cpu_sleeping,
    output logic                        break_req,
    output logic                        irq_req,
    output logic                        wake_req,
    output logic                        slave_start
);
    import ext_bus_pkg::*;

    typedef enum logic [4:0] {
        st_idle  = 5'h01,
        st_begin = 5'h02,
        st_wait  = 5'h04,
        st_hold  = 5'h08,
        st_int   = 5'h10
    } state_t;

    state_t                 state_q;
    bus_req_t               cur_q;
    logic [`BURST_IDX_W-1:0] idx_q;
    logic [3:0]             left_q;
    logic [31:0]            rbuf_q;
    bus_pins_t              sy1_q;
    bus_pins_t              sy2_q;
    logic [4:0]             ctl1_q;
    logic [4:0]             ctl2_q;
    logic                   done_s;
    logic                   hold_request_s;
    logic                   cs_s;
    logic                   sbi_s;
    logic                   int_s;
    logic                   hcyc_q;
    logic [1:0]             hcnt_q;
    logic                   hdone_q;
    logic                   hsrv_q;   // done already given for this cycle
    logic                   dram_en;
    logic [15:0]            dram_rd;
    logic [15:0]            hold_rdata_q;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers, two flops each
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sy1_q  <= '0;
            sy2_q  <= '0;
            ctl1_q <= 5'h1F;
            ctl2_q <= 5'h1F;
        end else begin
            sy1_q  <= pin_i;
            sy2_q  <= sy1_q;
            ctl1_q <= {done_i_n, hold_request_n, chip_select_n,
                       system_break_irq_n, ext_irq_n};
            ctl2_q <= ctl1_q;
        end
    end

    assign done_s = ~ctl2_q[4];
    assign hold_request_s = ~ctl2_q[3];
    assign cs_s   = ~ctl2_q[2];
    assign sbi_s  = ~ctl2_q[1];
    assign int_s  = ~ctl2_q[0];

    ////////////////////////////////////////////////////////////////////
    // interrupt pin roles
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            break_req   <= 1'b0;
            irq_req     <= 1'b0;
            wake_req    <= 1'b0;
            slave_start <= 1'b0;
        end else begin
            break_req   <= sbi_s;
            irq_req     <= int_s & irq_enable_flag;
            wake_req    <= cpu_sleeping & (sbi_s | int_s);
            slave_start <= sbi_s | int_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // master sequencer and hold arbitration
    assign req_ready = (state_q == st_idle) && !hold_request_s;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= st_idle;
            cur_q   <= '0;
            idx_q   <= '0;
            left_q  <= 4'h0;
        end else begin
            case (state_q)
                st_idle: begin
                    if (hold_request_s) begin
                        state_q <= st_hold;
                    end else if (req_valid) begin
                        cur_q   <= req;
                        idx_q   <= req.addr[`BURST_IDX_W-1:0];
                        if (req.size == req_block) begin
                            left_q <= (req.beats > `BURST_MAX) ? `BURST_MAX : req.beats;
                        end else if (req.size == req_word) begin
                            left_q <= 4'h2;
                        end else begin
                            left_q <= 4'h1;
                        end
                        // internal targets skip the external bus
                        state_q <= req_internal ? st_int : st_begin;
                    end
                end
                st_begin: begin
                    state_q <= st_wait;
                end
                st_wait: begin
                    if (done_s) begin
                        if (left_q == 4'h1) begin
                            state_q <= st_idle;
                        end else begin
                            state_q <= st_begin;
                            idx_q   <= idx_q + 1'b1;
                        end
                        left_q <= left_q - 4'h1;
                    end
                end
                st_int: begin
                    state_q <= st_idle;
                end
                st_hold: begin
                    if (!hold_request_s && !hcyc_q) begin
                        state_q <= st_idle;
                    end
                end
                default: begin
                    state_q <= st_idle;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read assembly: upper half first for words
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rbuf_q    <= '0;
            rsp_valid <= 1'b0;
            rsp_data  <= '0;
        end else begin
            rsp_valid <= 1'b0;
            if (state_q == st_wait && done_s) begin
                if (!cur_q.write) begin
                    rbuf_q <= {rbuf_q[15:0], sy2_q.data};
                end
                if (left_q == 4'h1) begin
                    rsp_valid <= 1'b1;
                    rsp_data  <= {rbuf_q[15:0], sy2_q.data};
                end
            end else if (state_q == st_int) begin
                rsp_valid <= 1'b1;
                rsp_data  <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bus pin drive during own cycles
    always_comb begin
        pin_o = '0;
        pin_o.cycle_begin_strobe_n = ~(state_q == st_begin);
        pin_o.space_select  = cur_q.io_space;
        pin_o.fetch_kind    = ~cur_q.fetch;
        pin_o.rd_wr_n       = ~cur_q.write;
        pin_o.multi_cycle_flag_n = ~(cur_q.size != req_half);
        pin_o.addr          = cur_q.addr;
        if (cur_q.size == req_word) begin
            pin_o.addr[0] = (left_q == 4'h1);
        end else if (cur_q.size == req_block) begin
            pin_o.addr[`BURST_IDX_W-1:0] = idx_q;
        end
        if (cur_q.write) begin
            // lane high maps to D0..D7, the upper byte
            pin_o.byte_lane_high_n = cur_q.lanes_n[1];
            pin_o.byte_lane_low_n  = cur_q.lanes_n[0];
        end else begin
            pin_o.byte_lane_high_n = 1'b0;
            pin_o.byte_lane_low_n  = 1'b0;
        end
        if (cur_q.size == req_word && left_q != 4'h1) begin
            pin_o.data = cur_q.wdata[31:16];
        end else begin
            pin_o.data = cur_q.wdata[15:0];
        end
        if (state_q == st_hold) begin
            pin_o.data = hold_rdata_q;
        end
    end

    // release address and control pins in hold; data and done are driven only for chip-select DRAM access
    assign pin_oe       = (state_q == st_begin) || (state_q == st_wait);
    assign data_oe      = (pin_oe && cur_q.write) ||
                          (state_q == st_hold && hcyc_q && sy2_q.rd_wr_n);
    assign hold_grant_n = ~(state_q == st_hold);
    assign done_oe      = (state_q == st_hold) && cs_s;
    assign done_o_n     = ~hdone_q;

    ////////////////////////////////////////////////////////////////////
    // hold-state DRAM slave cycle
    assign dram_en = (state_q == st_hold) && cs_s && !hcyc_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hcyc_q       <= 1'b0;
            hcnt_q       <= 2'h0;
            hdone_q      <= 1'b0;
            hsrv_q       <= 1'b0;
            hold_rdata_q <= '0;
        end else begin
            hdone_q <= 1'b0;
            if (dram_en) begin
                hcyc_q <= 1'b1;
                hsrv_q <= 1'b0;
                hcnt_q <= `DRAM_LAT;
            end else if (hcyc_q && hcnt_q != 2'h0) begin
                hcnt_q <= hcnt_q - 2'h1;
            end else if (hcyc_q && !hsrv_q && cs_s) begin
                // one done pulse per cycle, even while chip select lingers
                hdone_q      <= 1'b1;
                hsrv_q       <= 1'b1;
                hold_rdata_q <= dram_rd;
            end else if (hcyc_q && !cs_s) begin
                hcyc_q <= 1'b0;
            end
        end
    end

    // master drives address, lanes and direction into the device
    dram_store #(
        .AW (DRAM_AW)
    ) u_dram (
        .ref_clk (ref_clk),
        .en      (dram_en),
        .we      (~sy2_q.rd_wr_n),
        .lanes   (~{sy2_q.byte_lane_high_n, sy2_q.byte_lane_low_n}),
        .addr    (sy2_q.addr[DRAM_AW-1:0]),
        .wdata   (sy2_q.data),
        .rdata   (dram_rd)
    );
endmodule : ext_bus_port

// ---- dv/ext_bus_port_asserts.sv ----
// pin checker for the external bus port
// assumes it is bound onto ext_bus_port and sees its ports only
`timescale 1ns/1ps
module ext_bus_port_asserts
    import ext_bus_pkg::*;
(
    // watched ports
    input wire logic                   ref_clk,
    input wire logic                   rst,
    input wire logic                   req_valid,
    input wire logic                   req_ready,
    input wire ext_bus_pkg::bus_req_t  req,
    input wire logic                   req_internal,
    input wire ext_bus_pkg::bus_pins_t pin_o,
    input wire logic                   pin_oe,
    input wire logic                   done_o_n,
    input wire logic                   done_oe,
    input wire logic                   done_i_n,
    input wire logic                   hold_request_n,
    input wire logic                   chip_select_n,
    input wire logic                   hold_grant_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic take;
    // a request accepted at this edge
    assign take = req_valid && req_ready;
    ////////////////////////////////////////////////////////////////////////////////
    a_space_kind:
    assert property (take && !req_internal |=> pin_oe && pin_o.space_select == $past(req.io_space)
        && pin_o.fetch_kind == !$past(req.fetch)) else $error("space or kind level wrong");
    a_read_lanes:
    assert property (pin_oe && pin_o.rd_wr_n |-> !pin_o.byte_lane_high_n && !pin_o.byte_lane_low_n)
        else $error("read lanes not both low");
    a_write_lanes:
    assert property (take && req.write && req.size == req_half && !req_internal
        |=> {pin_o.byte_lane_high_n, pin_o.byte_lane_low_n} == $past(req.lanes_n))
        else $error("write lanes differ");
    a_begin_strobe:
    assert property ($rose(pin_oe) |-> !pin_o.cycle_begin_strobe_n) else $error("no begin strobe");
    a_internal_quiet:
    assert property (take && req_internal |=> !pin_oe [*2]) else $error("internal access on bus");
    a_word_order:
    assert property (take && req.size == req_word && !req_internal
        |=> !pin_o.multi_cycle_flag_n && !pin_o.addr[0]) else $error("word order wrong");
    a_wait_done:
    assert property ((done_i_n [*4]) ##0 pin_oe |=> pin_oe) else $error("cycle ended without done");
    a_hold_grant:
    assert property ($fell(hold_request_n) && req_ready |-> ##[1:6] !hold_grant_n)
        else $error("hold not granted");
    a_hold_float:
    assert property (!hold_grant_n |-> !pin_oe) else $error("pins driven in hold");
    a_dram_done:
    assert property ($fell(chip_select_n) && !hold_grant_n |-> ##[2:8] (done_oe && !done_o_n))
        else $error("no done for hold access");
endmodule : ext_bus_port_asserts

bind ext_bus_port ext_bus_port_asserts u_ext_bus_port_asserts (.*);

// ---- dv/bus_slave_model.sv ----
// slave responder for the port's own external cycles
// assumes resolved pins and the port's clock
`timescale 1ns/1ps
module bus_slave_model
    import ext_bus_pkg::*;
(
    // clock and bus seen
    input  wire logic                   ref_clk,
    input  wire ext_bus_pkg::bus_pins_t pins,
    input  wire logic                   pins_oe,
    input  wire logic [3:0]             waits,
    // answers
    output logic                        done_n,
    output logic [15:0]                 rdata
);
    logic        busy_q = 1'b0;
    logic [3:0]  cnt_q  = 4'h0;
    logic [15:0] last_q = 16'h0000;
    initial done_n = 1'b1;
    // data only while the cycle is open, a toggling pattern otherwise
    assign rdata = (busy_q || !done_n) ? pins.addr[15:0] ^ 16'h5A3C : ~last_q;
    ////////////////////////////////////////////////////////////////////////////////
    // count waits after each begin strobe, then pulse completion
    always @(posedge ref_clk) begin
        done_n <= 1'b1;
        last_q <= rdata;
        if (!busy_q && pins_oe && !pins.cycle_begin_strobe_n) begin
            busy_q <= 1'b1;
            cnt_q  <= waits;
        end else if (busy_q && cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else if (busy_q) begin
            busy_q <= 1'b0;
            done_n <= 1'b0;
        end
    end
endmodule : bus_slave_model

// ---- dv/external_system_bus_hold_port_tb.sv ----
// bench for the external bus port: own cycles, hold access, interrupt pins
// assumes the slave model and the bound checker
`timescale 1ns/1ps
module external_system_bus_hold_port_tb;
    import ext_bus_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        req_valid, req_ready, req_internal, rsp_valid, pin_oe, data_oe;
    logic        done_o_n, done_oe, done_i_n, slv_done_n, hold_request_n, chip_select_n;
    logic        hold_grant_n, system_break_irq_n, ext_irq_n, irq_enable_flag, cpu_sleeping;
    logic        break_req, irq_req, wake_req, slave_start;
    logic [31:0] rsp_data;
    bus_req_t    req;
    bus_pins_t   pin_o, pin_i, mst;
    logic [15:0] slv_data;
    logic [3:0]  waits;
    logic [1:0]  lanes_seen;
    logic [15:0] data_seen;
    logic        doe_seen;
    logic [22:0] seen_q[$];
    int          err_total = 0;
    int          n_checks = 0;
    int          cyc = 0;
    // clock
    always #12.5 ref_clk = ~ref_clk;
    ext_bus_port #(.DRAM_AW(6)) u_ext_bus_port (.*);
    bus_slave_model u_bus_slave_model (.ref_clk(ref_clk), .pins(pin_o), .pins_oe(pin_oe),
        .waits(waits), .done_n(slv_done_n), .rdata(slv_data));
    ////////////////////////////////////////////////////////////////////////////////
    // wire levels from every party's drive
    always_comb begin
        pin_i = pin_oe ? pin_o : mst;
        pin_i.data = data_oe ? pin_o.data : (pin_oe ? slv_data : mst.data);
    end
    assign done_i_n = done_oe ? done_o_n : slv_done_n;
    // record every begin strobe, cut a hang short
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (pin_oe && !pin_o.cycle_begin_strobe_n) begin
            seen_q.push_back(pin_o.addr);
            lanes_seen <= {pin_o.byte_lane_high_n, pin_o.byte_lane_low_n};
            data_seen  <= pin_o.data;
            doe_seen   <= data_oe;
        end
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (err_total == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    function automatic logic [15:0] f(logic [22:0] a);
        return a[15:0] ^ 16'h5A3C;
    endfunction : f
    function automatic bus_req_t mk(logic [22:0] a, logic io, logic fe, logic wr,
                                    req_size_t s, logic [3:0] n, logic [1:0] ln);
        return '{a, io, fe, wr, s, n, ln, 32'h1234ABCD};
    endfunction : mk
    // one access: offer, wait for take and answer
    task automatic run(bus_req_t r, logic internal);
        seen_q.delete();
        req = r;
        req_internal = internal;
        req_valid = 1'b1;
        for (int i = 0; i < 50 && req_ready !== 1'b1; i++) tick();
        tick();
        req_valid = 1'b0;
        for (int i = 0; i < 300 && rsp_valid !== 1'b1; i++) tick();
        check("rsp_valid", 32'(rsp_valid), 32'h1);
    endtask : run
    task automatic t_word();
        waits = 4'h3;
        run(mk(23'h000120, 1'b1, 1'b0, 1'b0, req_word, 4'h2, 2'b00), 1'b0);
        check("word beats", 32'(seen_q.size()), 32'h2);
        check("word first", 32'(seen_q[0]), 32'h120);
        check("word second", 32'(seen_q[1]), 32'h121);
        check("word data", rsp_data, {f(23'h120), f(23'h121)});
    endtask : t_word
    task automatic t_block();
        waits = 4'h0;
        run(mk(23'h000235, 1'b0, 1'b1, 1'b0, req_block, 4'h8, 2'b00), 1'b0);
        check("block beats", 32'(seen_q.size()), 32'h8);
        for (int i = 0; i < 8; i++) begin
            check("block addr", 32'(seen_q[i]), 32'h230 + 32'((5 + i) % 8));
        end
        check("block data", rsp_data, {f(23'h233), f(23'h234)});
    endtask : t_block
    task automatic t_write();
        waits = 4'h1;
        run(mk(23'h000300, 1'b0, 1'b0, 1'b1, req_half, 4'h1, 2'b01), 1'b0);
        check("write beats", 32'(seen_q.size()), 32'h1);
        check("write lanes", 32'(lanes_seen), 32'h1);
        check("write data", 32'({doe_seen, data_seen}), 32'h1ABCD);
        run(mk(23'h000010, 1'b0, 1'b0, 1'b0, req_half, 4'h1, 2'b00), 1'b1);
        check("internal beats", 32'(seen_q.size()), 32'h0);
    endtask : t_write
    task automatic dram(logic wr, logic [15:0] d, output logic [15:0] q);
        mst.addr = 23'h000015;
        mst.rd_wr_n = !wr;
        mst.byte_lane_high_n = 1'b0;
        mst.byte_lane_low_n = 1'b0;
        mst.data = d;
        chip_select_n = 1'b0;
        for (int i = 0; i < 20 && !(done_oe === 1'b1 && done_o_n === 1'b0); i++) tick();
        q = pin_o.data;
        check("hold done", 32'(done_o_n), 32'h0);
        tick();
        chip_select_n = 1'b1;
        mst = '1;
        repeat (2) tick();
        check("single done", 32'(done_o_n), 32'h1);
        tick();
    endtask : dram
    task automatic t_hold();
        logic [15:0] q;
        hold_request_n = 1'b0;
        for (int i = 0; i < 20 && hold_grant_n !== 1'b0; i++) tick();
        check("grant", 32'(hold_grant_n), 32'h0);
        check("released", 32'({pin_oe, req_ready}), 32'h0);
        dram(1'b1, 16'hBEEF, q);
        dram(1'b0, 16'h0000, q);
        check("dram data", 32'(q), 32'hBEEF);
        hold_request_n = 1'b1;
        for (int i = 0; i < 20 && hold_grant_n !== 1'b1; i++) tick();
        check("ungrant", 32'(hold_grant_n), 32'h1);
    endtask : t_hold
    task automatic t_irq();
        cpu_sleeping = 1'b1;
        system_break_irq_n = 1'b0;
        repeat (5) tick();
        check("break", 32'({break_req, wake_req, slave_start}), 32'h7);
        system_break_irq_n = 1'b1;
        ext_irq_n = 1'b0;
        repeat (5) tick();
        check("irq masked", 32'({irq_req, wake_req, slave_start}), 32'h3);
        irq_enable_flag = 1'b1;
        repeat (3) tick();
        check("irq", 32'(irq_req), 32'h1);
        ext_irq_n = 1'b1;
    endtask : t_irq
    // reset, then each scenario in turn
    initial begin
        req_valid = 1'b0;
        req_internal = 1'b0;
        req = '0;
        mst = '1;
        waits = 4'h1;
        hold_request_n = 1'b1;
        chip_select_n = 1'b1;
        system_break_irq_n = 1'b1;
        ext_irq_n = 1'b1;
        irq_enable_flag = 1'b0;
        cpu_sleeping = 1'b0;
        repeat (2) tick();
        rst = 1'b0;
        tick();
        t_word();
        t_block();
        t_write();
        t_hold();
        t_irq();
        wrap_up();
    end
endmodule : external_system_bus_hold_port_tb
